//--- shared/reset_seq_cfg.svh
// Constants for the reset and clock startup sequencer
// Contract
// [RL1] After power-on or brownout, hold core and peripheral clocks until 4096 reference ticks.
// [RL2] Drive reset pin low during the whole power-on or brownout stabilisation period.
// [RL3] On stop exit, count reference ticks; clocks stay off until recovery delay ends.
// [RL4] Wait mode stops core clocks while peripheral clocks keep running.
// [RL5] Every reset asserts core reset and selects normal or monitor reset vector.
// [RL6] Internal resets clear the stabilisation counter; external pin reset leaves it alone.
// [RL7] Each reset source sets its own flag in the reset cause register.
// [RL8] Pin flag needs pin low 67 ticks, or 4163 after power-on or brownout.
// [RL9] Internal resets drive pin low 32 ticks, hold core 32 more, then fetch.
// [RL10] Power-on or brownout: pin low 4096 plus 32 ticks, core released 32 later.
// [RL11] Power-on sets only the power-on flag and enables the clock generator output.
// [RL12] Watchdog overflow, possibly asynchronous, causes internal reset and sets watchdog flag.
// [RL13] Watchdog disabled only combinationally by test voltage in monitor or break state; the code registers the disable, one clock later.
// [RL14] Illegal opcode, or stop with stop disabled, sets bad opcode flag and resets.
// [RL15] Only opcode fetch from unmapped address resets; data access does not.
// [RL16] Brownout sets brownout flag and starts the long sequence with pin low.
// [RL17] Monitor entry reset triggers internal reset that also drives pin low.
// [RL18] The stabilisation counter is 13 bits wide.
// [RL19] Executing stop clears the stabilisation counter.
// [RL20] On stop exit sample fast recovery bit: 32 ticks if set, else 4096.
// [RL21] After any reset sequence the counter keeps counting freely.
// [RL22] The reset pin input is synchronised before its low time is counted.
`ifndef RESET_SEQ_CFG_SVH
`define RESET_SEQ_CFG_SVH
`define ADDR_CAUSE 8'h00
`define ADDR_CTRL 8'h04
`define ADDR_STATUS 8'h08
`define CAUSE_POR 7
`define CAUSE_PIN 6
`define CAUSE_WD 5
`define CAUSE_OPC 4
`define CAUSE_ADR 3
`define CAUSE_MON 2
`define CAUSE_LVI 1
`define CAUSE_RESET 8'h80
`define CTRL_FAST 0
`define CTRL_STOPEN 1
`define CTRL_MONITOR 2
`define CTRL_RESET 8'h00
`define REF_DIV 4'h4
`define LONG_TICKS 13'h1000
`define PHASE_TICKS 13'h0020
`define TAIL_TICKS 6'h20
`define PIN_MIN_TICKS 13'h0043
`define PIN_SAT 13'h1FFF
`define VEC_NORMAL 16'hFFFE
`define VEC_MONITOR 16'hFEFE
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

//--- shared/reset_seq_pkg.sv
// Types for the reset and clock startup sequencer
package reset_seq_pkg;
  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } axil_req_t;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_t;
  typedef enum logic [2:0] {S_RUN, S_PIN, S_CORE, S_EXT, S_EXT_TAIL, S_STOP, S_STOP_REC} seq_state_t;
endpackage

//--- verification/reset_and_clock_startup_sequencer_tb.sv
// Self-checking bench for the reset and clock startup sequencer
`timescale 1ns/1ns
`default_nettype none
module reset_and_clock_startup_sequencer_tb;
  import reset_seq_pkg::*;
  localparam int LR = 64;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  axil_req_t axil_req_i = '0;
  axil_rsp_t axil_rsp_o;
  logic [7:0] src = 8'h00;
  logic opcode_fetch_i = 1'b1;
  logic wait_mode_i = 1'b0;
  logic [2:0] tv = 3'h0;
  logic go = 1'b0;
  logic [12:0] ticks = 13'h0000;
  logic rst_pin_i, rst_pin_o, rst_pin_oe_o, core_reset_o, core_clk_en_o, periph_clk_en_o;
  logic clockgen_output_o, watchdog_disable_o;
  logic [15:0] reset_vector_o;
  logic [7:0] cause [5] = '{8'h10, 8'h08, 8'h04, 8'h20, 8'h10};
  logic [33:0] exp_q [$];
  int err_count = 0;
  int checks_done = 0;
  int n;

  always #2 clk_sys_i = ~clk_sys_i;

  reset_clock_sequencer #(.LONG_REF(13'h0040)) dut (
    .clk_sys_i, .reset_i, .axil_req_i, .axil_rsp_o,
    .power_up_detect_i(src[6]), .brownout_i(src[5]), .watchdog_overflow_i(src[3]),
    .bad_opcode_i(src[0]), .stop_instr_i(src[4]), .opcode_fetch_i, .fetch_unmapped_i(src[1]),
    .monitor_entry_reset_i(src[2]), .stop_wake_i(src[7]), .wait_mode_i, .break_state_i(tv[2]),
    .test_high_voltage_rst_i(tv[1]), .test_high_voltage_irq_i(tv[0]), .rst_pin_i, .rst_pin_o,
    .rst_pin_oe_o, .core_reset_o, .core_clk_en_o, .periph_clk_en_o, .clockgen_output_o,
    .watchdog_disable_o, .reset_vector_o
  );
  rst_pin_partner pin (.clk_i(clk_sys_i), .dev_oe_i(rst_pin_oe_o), .go_i(go), .ticks_i(ticks), .pin_o(rst_pin_i));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [33:0] got, input logic [33:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  function automatic logic near(input int t, input int e);
    return t >= e - 8 && t <= e + 8;
  endfunction
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys_i);
  endtask
  task automatic pulse(input int i);
    @(posedge clk_sys_i);
    src[i] <= 1'b1;
    @(posedge clk_sys_i);
    src[i] <= 1'b0;
  endtask
  task automatic tdone(input string s);
    $display("test %s done, %0d mismatches so far", s, err_count);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    axil_req_i.awaddr <= a;
    axil_req_i.wdata <= d;
    axil_req_i.wstrb <= 4'hF;
    axil_req_i.awvalid <= 1'b1;
    axil_req_i.wvalid <= 1'b1;
    axil_req_i.bready <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      if (axil_rsp_o.awready) axil_req_i.awvalid <= 1'b0;
      if (axil_rsp_o.wready) axil_req_i.wvalid <= 1'b0;
    end while (!axil_rsp_o.bvalid);
    chk(axil_rsp_o.bresp, (a <= 8'h08 && a[1:0] == 2'h0) ? 2'h0 : 2'h2, "bresp");
    axil_req_i.bready <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    @(posedge clk_sys_i);
    axil_req_i.araddr <= a;
    axil_req_i.arvalid <= 1'b1;
    axil_req_i.rready <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      if (axil_rsp_o.arready) axil_req_i.arvalid <= 1'b0;
    end while (!axil_rsp_o.rvalid);
    axil_req_i.rready <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  // Times pin release, core release and clock start in clocks
  task automatic seq(input int ep, input int ec, input int ek, input string m);
    int tp, tc, tk;
    tp = 0;
    tc = 0;
    tk = 0;
    for (int i = 1; i < 3000 && (tp <= 0 || tc <= 0); i++) begin
      @(posedge clk_sys_i);
      #1;
      if (tp == 0 && rst_pin_oe_o === 1'b1) tp = -1;
      if (tp < 0 && rst_pin_oe_o === 1'b0) tp = i;
      if (tc == 0 && core_reset_o === 1'b1) tc = -1;
      if (tc < 0 && core_reset_o === 1'b0) tc = i;
      if (tk == 0 && core_clk_en_o === 1'b0) tk = -1;
      if (tk < 0 && core_clk_en_o === 1'b1) tk = i;
    end
    chk(near(tp, ep), 1, {m, " pin"});
    chk(near(tc, ec), 1, {m, " core"});
    chk(near(tk, ek), 1, {m, " clocks"});
  endtask
  task automatic results;
    $display("counts: %0d checks, %0d mismatches", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Read monitor against the oldest note
  // ----------------------------------------
  always @(posedge clk_sys_i) begin
    if (axil_rsp_o.rvalid === 1'b1 && axil_req_i.rready === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk(1, 0, "unexpected read");
      end else begin
        chk({axil_rsp_o.rresp, axil_rsp_o.rdata}, exp_q.pop_front(), "read");
      end
    end
  end

  initial begin
    cyc(60000);
    err_count++;
    results();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h488FC65C));
    cyc(20);
    reset_i <= 1'b0;
    seq((LR + 32) * 4, (LR + 64) * 4, LR * 4, "por"); // Long sequence
    chk(clockgen_output_o, 1, "clkgen"); // Clock output on
    rd(8'h00, 34'h80); // Only power-on flag
    rd(8'h04, 34'h0);
    tdone("power on");
    for (int i = 0; i < 5; i++) begin
      pulse(i);
      seq(128, 256, 0, "short"); // Short sequence
      rd(8'h00, {26'h0, cause[i]}); // Own flag
      chk(reset_vector_o, 16'hFFFE, "vector"); // Normal vector
    end
    tdone("internal");
    opcode_fetch_i <= 1'b0;
    pulse(1);
    repeat (10) begin
      cyc(1);
      chk(core_reset_o, 0, "data access"); // No reset
    end
    opcode_fetch_i <= 1'b1;
    for (int m = 1; m >= 0; m--) begin
      wr(8'h04, m << 2);
      cyc(3);
      chk(reset_vector_o, m ? 16'hFEFE : 16'hFFFE, "mode vector"); // Vector select
      for (int k = 0; k < 8; k++) begin
        tv <= 3'(k);
        cyc(4);
        chk(watchdog_disable_o, (m && k[1:0] != 0) || (k[2] && k[1]), "wd off"); // Disable
      end
    end
    tv <= 3'h0;
    wait_mode_i <= 1'b1;
    cyc(4);
    chk({core_clk_en_o, periph_clk_en_o}, 2'b01, "wait"); // Wait clocks
    wait_mode_i <= 1'b0;
    tdone("modes");
    for (int f = 0; f < 2; f++) begin
      wr(8'h04, 32'(2 + f));
      pulse(4);
      cyc(4);
      chk(core_clk_en_o, 0, "stopped"); // Clocks off
      rd(8'h08, 34'h50000); // Counter cleared
      pulse(7);
      n = 0;
      while (core_clk_en_o !== 1'b1 && n < 2000) begin
        cyc(1);
        n++;
      end
      chk(near(n, f ? 128 : LR * 4), 1, "recovery"); // Stop delay
    end
    tdone("stop");
    wr(8'h04, 32'h0);
    for (int j = 0; j < 2; j++) begin
      ticks <= j ? 13'(70 + $urandom % 20) : 13'h0028;
      go <= 1'b1;
      cyc(1);
      go <= 1'b0;
      cyc(40);
      chk({core_reset_o, rst_pin_o}, 2'b10, "pin hold"); // Core held
      cyc(ticks * 4 + 32 * 4 + 40);
      chk(core_reset_o, 0, "pin release"); // Core released
      rd(8'h00, j ? 34'h50 : 34'h10); // Pin flag only when long enough
    end
    tdone("pin");
    for (int j = 5; j < 7; j++) begin
      pulse(j);
      seq((LR + 32) * 4, (LR + 64) * 4, LR * 4, "long"); // Long sequence
      rd(8'h00, j == 5 ? 34'h2 : 34'h80); // Flags
    end
    tdone("long");
    wr(8'h00, $urandom);
    rd(8'h00, 34'h80); // Cause unchanged by write
    wr(8'h0C, 32'h7);
    rd(8'h04, 34'h0);
    rd(8'h0C, {2'h2, 32'h0});
    tdone("bus");
    results();
  end
endmodule
`default_nettype wire

//--- verification/rst_pin_partner.sv
// Far-side reset pin model: pull-up plus an external driver
`timescale 1ns/1ns
`default_nettype none
module rst_pin_partner (
  input wire logic clk_i,
  input wire logic dev_oe_i,
  input wire logic go_i,
  input wire logic [12:0] ticks_i,
  output logic pin_o
);
  logic [15:0] hold = 16'h0000;
  // ----------------------------------------
  // External driver holds pin low for ticks
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (go_i) begin
      hold <= {1'b0, ticks_i, 2'b00}; // Hold time in clocks
    end else if (hold != 16'h0000) begin
      hold <= hold - 16'h0001;
    end
  end
  // Pull-up wins when nobody pulls low
  assign pin_o = !(dev_oe_i || (hold != 16'h0000));
endmodule
`default_nettype wire

//--- verilog/reset_clock_sequencer.sv
// Reset and clock startup sequencer with AXI4-Lite registers
//
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "reset_seq_cfg.svh"
module reset_clock_sequencer #(
  parameter logic [12:0] LONG_REF = `LONG_TICKS
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire reset_seq_pkg::axil_req_t axil_req_i,
  output var reset_seq_pkg::axil_rsp_t axil_rsp_o,
  input wire logic power_up_detect_i,
  input wire logic brownout_i,
  input wire logic watchdog_overflow_i,
  input wire logic bad_opcode_i,
  input wire logic stop_instr_i,
  input wire logic opcode_fetch_i,
  input wire logic fetch_unmapped_i,
  input wire logic monitor_entry_reset_i,
  input wire logic stop_wake_i,
  input wire logic wait_mode_i,
  input wire logic break_state_i,
  input wire logic test_high_voltage_rst_i,
  input wire logic test_high_voltage_irq_i,
  input wire logic rst_pin_i,
  output logic rst_pin_o,
  output logic rst_pin_oe_o,
  output logic core_reset_o,
  output logic core_clk_en_o,
  output logic periph_clk_en_o,
  output logic clockgen_output_o,
  output logic watchdog_disable_o,
  output logic [15:0] reset_vector_o
);
  import reset_seq_pkg::*;

  seq_state_t state, next_state;
  logic [12:0] cnt;
  logic [12:0] pin_low_cnt;
  logic [5:0] tail_cnt;
  logic [3:0] div_cnt;
  logic ref_tick;
  logic long_seq, long_pin, stop_fast;
  logic wd_s1, wd_s2, wd_s3, pin_s1, pin_s2;
  logic [7:0] cause, ctrl;
  logic aw_got, w_got;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // ----------------------------------------
  // Reference tick divider
  // ----------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || div_cnt == `REF_DIV - 4'h1) begin
      div_cnt <= 4'h0;
    end else begin
      div_cnt <= div_cnt + 4'h1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      ref_tick <= 1'b0;
    end else begin
      ref_tick <= (div_cnt == `REF_DIV - 4'h1);
    end
  end

  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      wd_s1 <= 1'b0;
      wd_s2 <= 1'b0;
      wd_s3 <= 1'b0;
      pin_s1 <= 1'b1;
      pin_s2 <= 1'b1;
    end else begin
      wd_s1 <= watchdog_overflow_i; // [RL12]
      wd_s2 <= wd_s1;
      wd_s3 <= wd_s2;
      pin_s1 <= rst_pin_i; // [RL22]
      pin_s2 <= pin_s1;
    end
  end

  // ----------------------------------------
  // Reset requests
  // ----------------------------------------
  wire wd_evt = wd_s2 & ~wd_s3; // [RL12]
  wire stop_illegal = stop_instr_i & ~ctrl[`CTRL_STOPEN]; // [RL14]
  wire opcode_bad = bad_opcode_i | stop_illegal; // [RL14]
  wire addr_bad = opcode_fetch_i & fetch_unmapped_i; // [RL15]
  wire long_req = power_up_detect_i | brownout_i; // [RL16]
  wire short_req = wd_evt | opcode_bad | addr_bad | monitor_entry_reset_i; // [RL17]
  wire in_seq = (state == S_PIN) || (state == S_CORE);
  wire start_short = short_req & ~in_seq;
  wire int_start = long_req | start_short;
  wire ext_low = ~pin_s2 & ~rst_pin_oe_o;
  wire ext_ok = (state == S_RUN) || (state == S_STOP) || (state == S_STOP_REC);
  wire ext_start = ext_low & ext_ok & ~int_start;
  wire stop_go = stop_instr_i & ctrl[`CTRL_STOPEN] & (state == S_RUN) & ~int_start & ~ext_start;
  wire [12:0] pin_end = long_seq ? LONG_REF + `PHASE_TICKS : `PHASE_TICKS; // [RL9] [RL10]
  wire [12:0] core_end = pin_end + `PHASE_TICKS; // [RL9] [RL10]
  wire [12:0] pin_thr = long_pin ? LONG_REF + `PIN_MIN_TICKS : `PIN_MIN_TICKS; // [RL8]
  wire pin_flag_evt = ~pin_s2 & ref_tick & (pin_low_cnt == pin_thr - 13'h1); // [RL8]
  wire [12:0] rec_end = stop_fast ? `PHASE_TICKS : LONG_REF; // [RL20]
  wire clk_hold = (state == S_PIN && long_seq && cnt < LONG_REF) // [RL1]
    || state == S_STOP || state == S_STOP_REC; // [RL3]

  // ----------------------------------------
  // Sequencer state
  // ----------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      S_RUN: if (stop_go) next_state = S_STOP;
      S_PIN: if (cnt >= pin_end) next_state = S_CORE;
      S_CORE: if (cnt >= core_end) next_state = S_RUN;
      S_EXT: if (pin_s2) next_state = S_EXT_TAIL;
      S_EXT_TAIL: begin
        if (!pin_s2) begin
          next_state = S_EXT;
        end else if (tail_cnt >= `TAIL_TICKS) begin
          next_state = S_RUN;
        end
      end
      S_STOP: if (stop_wake_i) next_state = S_STOP_REC;
      S_STOP_REC: if (cnt >= rec_end) next_state = S_RUN; // [RL3]
    endcase
    if (ext_start) begin
      next_state = S_EXT;
    end
    if (int_start) begin
      next_state = S_PIN;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      state <= S_PIN;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // Stabilisation counter
  // ----------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || int_start || stop_go) begin
      cnt <= 13'h0000; // [RL6] [RL19]
    end else if (ref_tick && state != S_STOP) begin
      cnt <= cnt + 13'h0001; // [RL18] [RL21]
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i || long_req) begin
      long_seq <= 1'b1; // [RL16]
    end else if (start_short) begin
      long_seq <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i || long_req) begin
      long_pin <= 1'b1;
    end else if (pin_s2 && state != S_PIN) begin
      long_pin <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      stop_fast <= 1'b0;
    end else if (state == S_STOP && stop_wake_i) begin
      stop_fast <= ctrl[`CTRL_FAST]; // [RL20]
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i || state != S_EXT_TAIL) begin
      tail_cnt <= 6'h00;
    end else if (ref_tick) begin
      tail_cnt <= tail_cnt + 6'h01;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i || pin_s2) begin
      pin_low_cnt <= 13'h0000;
    end else if (ref_tick && pin_low_cnt != `PIN_SAT) begin
      pin_low_cnt <= pin_low_cnt + 13'h0001; // [RL8]
    end
  end

  // ----------------------------------------
  // Reset cause
  // ----------------------------------------
  wire [7:0] short_cause = {2'h0, wd_evt, opcode_bad, addr_bad, monitor_entry_reset_i, 2'h0};
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || power_up_detect_i) begin
      cause <= `CAUSE_RESET; // [RL11]
    end else if (brownout_i) begin
      cause <= 8'h01 << `CAUSE_LVI; // [RL16]
    end else if (start_short) begin
      cause <= short_cause; // [RL7]
    end else if (pin_flag_evt) begin
      cause <= cause | (8'h01 << `CAUSE_PIN); // [RL8]
    end
  end

  // ----------------------------------------
  // Output flops
  // ----------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      rst_pin_o <= 1'b0;
      rst_pin_oe_o <= 1'b0;
      core_reset_o <= 1'b1;
      core_clk_en_o <= 1'b0;
      periph_clk_en_o <= 1'b0;
      clockgen_output_o <= 1'b0;
      watchdog_disable_o <= 1'b0;
      reset_vector_o <= `VEC_NORMAL;
    end else begin
      rst_pin_o <= 1'b0;
      rst_pin_oe_o <= (state == S_PIN); // [RL2] [RL9] [RL17]
      core_reset_o <= (state != S_RUN) && (state != S_STOP) && (state != S_STOP_REC); // [RL5]
      core_clk_en_o <= ~clk_hold & ~wait_mode_i; // [RL4]
      periph_clk_en_o <= ~clk_hold; // [RL1] [RL4]
      clockgen_output_o <= 1'b1; // [RL11]
      watchdog_disable_o <= (ctrl[`CTRL_MONITOR] & (test_high_voltage_rst_i | test_high_voltage_irq_i))
        | (break_state_i & test_high_voltage_rst_i); // [RL13]
      reset_vector_o <= ctrl[`CTRL_MONITOR] ? `VEC_MONITOR : `VEC_NORMAL; // [RL5]
    end
  end

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  wire aw_hs = axil_req_i.awvalid & axil_rsp_o.awready;
  wire w_hs = axil_req_i.wvalid & axil_rsp_o.wready;
  wire b_hs = axil_req_i.bready & axil_rsp_o.bvalid;
  wire ar_hs = axil_req_i.arvalid & axil_rsp_o.arready;
  wire r_hs = axil_req_i.rready & axil_rsp_o.rvalid;
  wire wr_do = aw_got & w_got & ~axil_rsp_o.bvalid;
  wire wr_ctrl = aw_addr == `ADDR_CTRL;
  wire wr_hit = wr_ctrl || aw_addr == `ADDR_CAUSE || aw_addr == `ADDR_STATUS;
  wire rd_cause = axil_req_i.araddr == `ADDR_CAUSE;
  wire rd_ctrl = axil_req_i.araddr == `ADDR_CTRL;
  wire rd_stat = axil_req_i.araddr == `ADDR_STATUS;
  wire [31:0] stat_word = {13'h0000, state, 3'h0, cnt};
  wire [31:0] rd_word = rd_cause ? {24'h000000, cause} : rd_ctrl ? {24'h000000, ctrl} : rd_stat ? stat_word : 32'h0;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      aw_got <= 1'b0;
      aw_addr <= 8'h00;
    end else if (aw_hs) begin
      aw_got <= 1'b1;
      aw_addr <= axil_req_i.awaddr;
    end else if (b_hs) begin
      aw_got <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      w_got <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else if (w_hs) begin
      w_got <= 1'b1;
      w_data <= axil_req_i.wdata;
      w_strb <= axil_req_i.wstrb;
    end else if (b_hs) begin
      w_got <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      ctrl <= `CTRL_RESET;
    end else if (wr_do && wr_ctrl && w_strb[0]) begin
      ctrl <= w_data[7:0];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      axil_rsp_o <= '0;
    end else begin
      axil_rsp_o.awready <= ~aw_got & ~aw_hs;
      axil_rsp_o.wready <= ~w_got & ~w_hs;
      if (wr_do) begin
        axil_rsp_o.bvalid <= 1'b1;
        axil_rsp_o.bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (b_hs) begin
        axil_rsp_o.bvalid <= 1'b0;
      end
      axil_rsp_o.arready <= ~ar_hs & ~axil_rsp_o.rvalid;
      if (ar_hs) begin
        axil_rsp_o.rvalid <= 1'b1;
        axil_rsp_o.rdata <= rd_word;
        axil_rsp_o.rresp <= (rd_cause | rd_ctrl | rd_stat) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (r_hs) begin
        axil_rsp_o.rvalid <= 1'b0;
        axil_rsp_o.arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);

  sequence s_core_done;
    state == S_CORE ##1 state == S_RUN;
  endsequence

  a_long_clock_hold: assert property ((state == S_PIN && long_seq && cnt < LONG_REF) |=> !periph_clk_en_o) // [RL1]
    else $error("clocks ran during stabilisation");
  a_pin_driven_low: assert property ((state == S_PIN) |=> rst_pin_oe_o && !rst_pin_o) // [RL2]
    else $error("reset pin not driven in pin phase");
  a_stop_clock_off: assert property ((state == S_STOP_REC) |=> !core_clk_en_o && !periph_clk_en_o) // [RL3]
    else $error("clocks active during stop recovery");
  a_wait_core_only: assert property ((wait_mode_i && state == S_RUN) |=> !core_clk_en_o && periph_clk_en_o) // [RL4]
    else $error("wait mode clock gating wrong");
  a_vector_select: assert property (ctrl[`CTRL_MONITOR] |=> reset_vector_o == `VEC_MONITOR) // [RL5]
    else $error("monitor vector not selected");
  a_int_clears_count: assert property (int_start |=> cnt == 13'h0000 && state == S_PIN) // [RL6]
    else $error("internal reset did not clear counter");
  a_watchdog_flag: assert property ((wd_evt && !long_req && !in_seq) |=> cause[`CAUSE_WD]) // [RL7] [RL12]
    else $error("watchdog flag missing");
  a_pin_flag_set: assert property ((pin_flag_evt && !int_start) |=> cause[`CAUSE_PIN]) // [RL8]
    else $error("pin flag missing");
  a_core_release: assert property (s_core_done |=> !core_reset_o) // [RL9]
    else $error("core reset not released");
  a_long_pin_hold: assert property ((state == S_PIN && long_seq && cnt < LONG_REF + `PHASE_TICKS) |=> state == S_PIN) // [RL10]
    else $error("long pin phase ended early");
  a_por_cause_only: assert property (power_up_detect_i |=> cause == `CAUSE_RESET ##1 clockgen_output_o) // [RL11]
    else $error("power-on cause wrong");
  a_wd_disable_gate: assert property ((ctrl[`CTRL_MONITOR] && test_high_voltage_irq_i) |=> watchdog_disable_o) // [RL13]
    else $error("watchdog not disabled");
  a_stop_illegal: assert property ((stop_illegal && !long_req && !in_seq) |=> cause[`CAUSE_OPC] && state == S_PIN) // [RL14]
    else $error("illegal stop not reset");
  a_bad_fetch_flag: assert property ((addr_bad && !long_req && !in_seq) |=> cause[`CAUSE_ADR]) // [RL15]
    else $error("bad fetch flag missing");
  a_brownout_long: assert property ((brownout_i && !power_up_detect_i) |=> cause[`CAUSE_LVI] && long_seq ##1 rst_pin_oe_o) // [RL16]
    else $error("brownout sequence wrong");
  a_stop_clears: assert property (stop_go |=> cnt == 13'h0000 && state == S_STOP) // [RL19]
    else $error("stop did not clear counter");
  a_stop_fast_pick: assert property ((state == S_STOP && stop_wake_i) |=> stop_fast == $past(ctrl[`CTRL_FAST])) // [RL20]
    else $error("recovery option not sampled");
  a_count_free: assert property ((state == S_RUN && ref_tick && !int_start && !stop_go) |=> cnt == 13'($past(cnt) + 13'h0001)) // [RL21]
    else $error("counter not free running");
  a_monitor_entry: assert property ((monitor_entry_reset_i && !long_req && !in_seq) |=> cause[`CAUSE_MON] ##1 rst_pin_oe_o) // [RL17]
    else $error("monitor entry reset missing");
  a_ext_count_keep: assert property ((state == S_EXT && ref_tick && !int_start) |=> cnt == 13'($past(cnt) + 13'h0001)) // [RL6]
    else $error("external reset disturbed counter");
  a_stop_count_hold: assert property ((state == S_STOP && !int_start) |=> cnt == $past(cnt)) // [RL3]
    else $error("counter moved while stopped");
  a_core_in_ext: assert property ((state == S_EXT) |=> core_reset_o) // [RL5]
    else $error("core not held in external reset");
endmodule
`default_nettype wire
